/* File: hw/sbs_pkg.sv */
package sbs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int LANES = 4;
  localparam int LOW_W = 2;

  // ----------------------------------------------------------------
  // burst counter
  // ----------------------------------------------------------------
  localparam logic [1:0] STEP_RST = 2'h0;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] START_RST = 2'h0;

  // ----------------------------------------------------------------
  // values after reset, and the all-lanes write mask
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_ALL = 4'hF;
  localparam logic BYPASS_RST = 1'b1;
  localparam logic SLEEP_RST = 1'b0;

  // ----------------------------------------------------------------
  // access state, gray coded along desel -> active -> sleep
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_DESEL = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_SLEEP = 2'b11
  } sbs_state_t;

endpackage

/* File: hw/sbs_burst_counter.sv */
module sbs_burst_counter
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic advance,
  input wire logic interleaved,
  input wire logic [sbs_pkg::LOW_W-1:0] startBits,
  output logic [sbs_pkg::LOW_W-1:0] lowNow
);
  import sbs_pkg::*;

  logic [LOW_W-1:0] start_q;
  logic [LOW_W-1:0] start_d;
  logic [LOW_W-1:0] step_q;
  logic [LOW_W-1:0] step_d;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb
  begin
    start_d = start_q;
    step_d = step_q;
    if (load)
    begin
      start_d = startBits; // [R1]
      step_d = STEP_RST;
    end
    else if (advance)
    begin
      // two bits wrap by themselves, so the fifth address is the start again
      step_d = LOW_W'(step_q + STEP_ONE); // [R5] [R14]
    end
    if (interleaved)
    begin
      lowNow = start_d ^ step_d; // [R9] [R12]
    end
    else
    begin
      lowNow = LOW_W'(start_d + step_d); // [R9] [R11]
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      start_q <= START_RST;
      step_q <= STEP_RST;
    end
    else
    begin
      start_q <= start_d;
      step_q <= step_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence advLin;
    advance && !load && !interleaved;
  endsequence

  sequence advInt;
    advance && !load && interleaved;
  endsequence

  a_linear_wrap: assert property (@(posedge ref_clk) disable iff (!rstn) // [R14]
    (load && !interleaved) ##1 advLin [*4] |-> lowNow == $past(startBits, 4))
    else $error("linear burst did not wrap to start");

  a_linear_two: assert property (@(posedge ref_clk) disable iff (!rstn) // [R11]
    (load && !interleaved) ##1 advLin [*2] |-> lowNow == LOW_W'($past(startBits, 2) + 2'h2))
    else $error("linear burst third address wrong");

  a_interleave_seq: assert property (@(posedge ref_clk) disable iff (!rstn) // [R12]
    (load && interleaved) ##1 advInt [*3] |-> lowNow == ($past(startBits, 3) ^ 2'h3))
    else $error("interleaved burst fourth address wrong");

  a_suspend_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // [R5]
    !load && !advance |=> $stable(step_q))
    else $error("burst counter moved without advance");

endmodule

/* File: hw/sbs_control.sv */
// Behaviour
// R1: the two low address bits are also the burst counter start value.
// R2: each byte lane has its own low-active write enable, gated by the byte-write gate.
// R3: byte-write gate low writes exactly the enabled lanes; others keep contents.
// R4: global write low writes all lanes regardless of other write inputs.
// R5: burst counter steps only in cycles with burst advance low.
// R6: processor and controller strobes, either low at an edge, load an address; the code ignores the processor strobe while the first low enable is high.
// R7: sleep request high puts the device in standby; low means normal operation.
// R8: bypass select low gives flow-through reads; high gives pipelined reads.
// R9: burst order select low gives linear order, high gives interleaved.
// R10: bypass select defaults high and sleep defaults low when unconnected.
// R11: linear order counts the low bits up modulo four from the start.
// R12: interleaved order is start XOR a step count running 0 to 3.
// R13: selected only when both low enables are low and the high enable high.
// R14: after four addresses the counter wraps to the start and repeats.
// R15: the far side may hold the processor strobe high, controller strobe low.
// R16: a captured deselect turns outputs off one stage before read data would.
// R17: output enable high turns drivers off; low only enables read-activated drivers.
module sbs_control
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [sbs_pkg::ADDR_W-1:0] addrIn,
  input wire logic selectLowFirst_n,
  input wire logic selectLowSecond_n,
  input wire logic selectHigh,
  input wire logic processorAddressStrobe_n,
  input wire logic controllerAddressStrobe_n,
  input wire logic burstAdvance_n,
  input wire logic byteWriteGate_n,
  input wire logic globalWrite_n,
  input wire logic [sbs_pkg::LANES-1:0] laneWriteEnables_n,
  input wire logic outputEnable_n,
  input wire logic outputBypassSelect,
  input wire logic burstOrderSelect,
  input wire logic sleepRequest,
  output logic [sbs_pkg::ADDR_W-1:0] memAddr_q,
  output logic [sbs_pkg::LANES-1:0] memLaneWrite_q,
  output logic memRead_q,
  output logic dataDrive_q,
  output logic outputRegUse_q,
  output logic sleepActive_q
);
  import sbs_pkg::*;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic selected;
  logic procLoad;
  logic loadNow;
  logic loadSel;
  logic deselNow;
  logic continueNow;
  logic accessNow;
  logic writeReq;
  logic writeNow;
  logic readNow;
  logic killNow;
  logic advanceNow;
  logic [LANES-1:0] lanesReq;
  logic [LOW_W-1:0] lowNow;

  sbs_state_t state_q;
  sbs_state_t state_d;
  logic [ADDR_W-LOW_W-1:0] highAddr_q;
  logic [ADDR_W-LOW_W-1:0] highAddr_d;
  logic readStage_q;
  logic readStage_d;
  logic [ADDR_W-1:0] memAddr_d;
  logic [LANES-1:0] memLaneWrite_d;
  logic memRead_d;
  logic dataDrive_d;
  logic outputRegUse_d;
  logic sleepActive_d;

  always_comb
  begin
    selected = !selectLowFirst_n && !selectLowSecond_n && selectHigh; // [R13]
    // the processor strobe is ignored while the first low enable is high
    procLoad = !processorAddressStrobe_n && !selectLowFirst_n;
    loadNow = !sleepRequest && (procLoad || !controllerAddressStrobe_n); // [R6] [R15]
    loadSel = loadNow && selected;
    deselNow = loadNow && !selected; // [R13]
    continueNow = !sleepRequest && !loadNow && (state_q == ST_ACTIVE);
    advanceNow = continueNow && !burstAdvance_n; // [R5]
    accessNow = loadSel || continueNow;
    if (!globalWrite_n)
    begin
      lanesReq = LANES_ALL; // [R4]
    end
    else if (!byteWriteGate_n)
    begin
      lanesReq = ~laneWriteEnables_n; // [R2] [R3]
    end
    else
    begin
      lanesReq = LANES_NONE;
    end
    writeReq = !globalWrite_n || !byteWriteGate_n;
    // a processor-strobe load is always a read
    writeNow = accessNow && writeReq && !(loadSel && procLoad);
    readNow = accessNow && !writeNow;
    killNow = deselNow || writeNow || sleepRequest; // [R16]
  end

  sbs_burst_counter u_counter
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .load(loadSel),
    .advance(advanceNow),
    .interleaved(burstOrderSelect),
    .startBits(addrIn[LOW_W-1:0]),
    .lowNow(lowNow)
  );

  // ----------------------------------------------------------------
  // access state and outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    highAddr_d = highAddr_q;
    memAddr_d = memAddr_q;
    memLaneWrite_d = LANES_NONE;
    memRead_d = 1'b0;
    readStage_d = readNow;
    dataDrive_d = 1'b0;
    outputRegUse_d = outputBypassSelect; // [R8]
    sleepActive_d = sleepRequest; // [R7]
    if (sleepRequest)
    begin
      state_d = ST_SLEEP; // [R7]
    end
    else if (deselNow)
    begin
      state_d = ST_DESEL;
    end
    else if (loadSel)
    begin
      state_d = ST_ACTIVE;
      highAddr_d = addrIn[ADDR_W-1:LOW_W];
    end
    else if (state_q == ST_SLEEP)
    begin
      state_d = ST_DESEL;
    end
    if (accessNow)
    begin
      memAddr_d = {highAddr_d, lowNow}; // [R1]
      memRead_d = readNow;
      if (writeNow)
      begin
        memLaneWrite_d = lanesReq; // [R3] [R4]
      end
    end
    // drivers only come on for a read and never while output enable is high
    if (!outputEnable_n && !killNow) // [R17] [R16]
    begin
      if (outputBypassSelect)
      begin
        dataDrive_d = readStage_q; // [R8]
      end
      else
      begin
        dataDrive_d = readNow; // [R8]
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state_q <= ST_DESEL;
      highAddr_q <= ADDR_RST[ADDR_W-1:LOW_W];
      memAddr_q <= ADDR_RST;
      memLaneWrite_q <= LANES_NONE;
      memRead_q <= 1'b0;
      readStage_q <= 1'b0;
      dataDrive_q <= 1'b0;
      // pads pull these to pipelined and awake when left open
      outputRegUse_q <= BYPASS_RST; // [R10]
      sleepActive_q <= SLEEP_RST; // [R10]
    end
    else
    begin
      state_q <= state_d;
      highAddr_q <= highAddr_d;
      memAddr_q <= memAddr_d;
      memLaneWrite_q <= memLaneWrite_d;
      memRead_q <= memRead_d;
      readStage_q <= readStage_d;
      dataDrive_q <= dataDrive_d;
      outputRegUse_q <= outputRegUse_d;
      sleepActive_q <= sleepActive_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence selLoad;
    loadSel;
  endsequence

  sequence pipeRead;
    readNow && outputBypassSelect && !outputEnable_n;
  endsequence

  sequence pipeClear;
    !killNow && !outputEnable_n && outputBypassSelect;
  endsequence

  a_global_write_all: assert property (@(posedge ref_clk) disable iff (!rstn) // [R4]
    accessNow && !globalWrite_n && !(loadSel && procLoad) |=> memLaneWrite_q == LANES_ALL)
    else $error("global write did not write all lanes");

  a_lane_write_gate: assert property (@(posedge ref_clk) disable iff (!rstn) // [R3]
    accessNow && !(loadSel && procLoad) && globalWrite_n && !byteWriteGate_n
    |=> memLaneWrite_q == ~$past(laneWriteEnables_n))
    else $error("byte write lanes wrong");

  a_strobe_load_addr: assert property (@(posedge ref_clk) disable iff (!rstn) // [R6]
    selLoad |=> memAddr_q == $past(addrIn))
    else $error("strobe load did not take the external address");

  a_proc_read_only: assert property (@(posedge ref_clk) disable iff (!rstn) // [R6]
    selLoad and procLoad |=> memRead_q && memLaneWrite_q == LANES_NONE)
    else $error("processor strobe load was not a read");

  a_deselect_idle: assert property (@(posedge ref_clk) disable iff (!rstn) // [R13]
    deselNow |=> !memRead_q && memLaneWrite_q == LANES_NONE && !dataDrive_q)
    else $error("deselect still accessed or drove");

  a_sleep_standby: assert property (@(posedge ref_clk) disable iff (!rstn) // [R7]
    sleepRequest |=> sleepActive_q && !memRead_q && memLaneWrite_q == LANES_NONE && !dataDrive_q)
    else $error("sleep did not idle the device");

  a_flow_drive: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
    readNow && !outputBypassSelect && !outputEnable_n |=> dataDrive_q)
    else $error("flow-through read did not drive next cycle");

  a_pipe_drive: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
    pipeRead ##1 pipeClear |=> dataDrive_q)
    else $error("pipelined read did not drive two cycles later");

  a_pipe_late: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
    !readStage_q && outputBypassSelect |=> !dataDrive_q)
    else $error("pipelined drive came too early");

  a_kill_drive: assert property (@(posedge ref_clk) disable iff (!rstn) // [R16]
    killNow |=> !dataDrive_q)
    else $error("drivers not turned off after deselect or write");

  a_oe_off: assert property (@(posedge ref_clk) disable iff (!rstn) // [R17]
    outputEnable_n |=> !dataDrive_q)
    else $error("drivers on while output enable high");

  a_suspend_addr: assert property (@(posedge ref_clk) disable iff (!rstn) // [R5]
    continueNow && burstAdvance_n && $past(accessNow) |=> memAddr_q == $past(memAddr_q))
    else $error("address moved on a suspend cycle");

endmodule

/* File: verification/sbs_host_model.sv */
module sbs_host_model
(
  input wire logic ref_clk,
  output logic [sbs_pkg::ADDR_W-1:0] addrIn,
  output logic [2:0] chipSel,
  output logic [1:0] strobes_n,
  output logic advance_n,
  output logic [1:0] writes_n,
  output logic [3:0] lanes_n,
  output logic [3:0] modes
);
  timeunit 1ns;
  timeprecision 1ps;
  import sbs_pkg::*;

  // ----------------------------------------------------------------
  // bus driver: one command per rising edge, held a whole cycle
  // ----------------------------------------------------------------
  logic [3:0] modeNext = 4'h4;

  initial
  begin
    addrIn = ADDR_RST;
    chipSel = 3'b001;
    strobes_n = 2'b11;
    advance_n = 1'b1;
    writes_n = 2'b11;
    lanes_n = 4'hF;
    modes = 4'h4;
  end

  task automatic send(input logic [1:0] stb, input logic burst_advance, input logic [1:0] wr,
                      input logic [3:0] ln, input logic [2:0] cs, input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    strobes_n <= stb;
    advance_n <= burst_advance;
    writes_n <= wr;
    lanes_n <= ln;
    chipSel <= cs;
    modes <= modeNext;
    // unstrobed cycles carry junk so a stray reload shows up
    addrIn <= (stb == 2'b11) ? ~addrIn : a;
    #1;
  endtask
endmodule

/* File: verification/test_sbs_control.sv */
module test_sbs_control;
  timeunit 1ns;
  timeprecision 1ps;
  import sbs_pkg::*;

`define CHK(what, exp, got) \
  begin \
    testsRun++; \
    if ((got) !== (exp)) \
    begin \
      nFail++; \
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
    end \
  end

  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addrIn, memAddr_q, a;
  logic [2:0] chipSel;
  logic [1:0] strobes_n, writes_n, lo, st, wrN;
  logic advance_n, memRead_q, dataDrive_q, outputRegUse_q, sleepActive_q;
  logic [3:0] lanes_n, modes, memLaneWrite_q, ln;
  int nFail = 0;
  int testsRun = 0;
  logic [3:0] ddMode [4] = '{4'h0, 4'h4, 4'h4, 4'h8};
  logic [1:0] ddExp [4] = '{2'b10, 2'b00, 2'b01, 2'b00};

  always #12.5 ref_clk = ~ref_clk;

  sbs_host_model host_u (.ref_clk(ref_clk), .addrIn(addrIn), .chipSel(chipSel), .strobes_n(strobes_n),
    .advance_n(advance_n), .writes_n(writes_n), .lanes_n(lanes_n), .modes(modes));

  sbs_control dut_u (.ref_clk(ref_clk), .rstn(rstn), .addrIn(addrIn), .selectLowFirst_n(chipSel[2]),
    .selectLowSecond_n(chipSel[1]), .selectHigh(chipSel[0]), .processorAddressStrobe_n(strobes_n[1]),
    .controllerAddressStrobe_n(strobes_n[0]), .burstAdvance_n(advance_n), .byteWriteGate_n(writes_n[0]),
    .globalWrite_n(writes_n[1]), .laneWriteEnables_n(lanes_n), .outputEnable_n(modes[3]),
    .outputBypassSelect(modes[2]), .burstOrderSelect(modes[1]), .sleepRequest(modes[0]),
    .memAddr_q(memAddr_q), .memLaneWrite_q(memLaneWrite_q), .memRead_q(memRead_q),
    .dataDrive_q(dataDrive_q), .outputRegUse_q(outputRegUse_q), .sleepActive_q(sleepActive_q));

  // ----------------------------------------------------------------
  // access tasks: results of a command show after the next call
  // ----------------------------------------------------------------
  task automatic rd(input logic [ADDR_W-1:0] adr);
    host_u.send(2'b10, 1'b1, 2'b11, 4'hF, 3'b001, adr);
  endtask

  task automatic nx(input logic burst_advance);
    host_u.send(2'b11, burst_advance, 2'b11, 4'hF, 3'b001, ADDR_RST);
  endtask

  task automatic ds;
    host_u.send(2'b10, 1'b1, 2'b11, 4'hF, 3'b101, ADDR_RST);
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    nFail++;
    print_verdict;
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    `CHK("bypass default", 1'b1, outputRegUse_q)
    `CHK("sleep default", 1'b0, sleepActive_q)
    for (int o = 0; o < 2; o++)
    begin
      for (int s = 0; s < 4; s++)
      begin
        host_u.modeNext = {2'b01, o[0], 1'b0};
        a = {17'h0B6C5, s[1:0]};
        rd(a);
        // four advances wrap to the start, then one suspend holds
        for (int j = 1; j < 7; j++)
        begin
          nx(j > 4);
          st = (j >= 5) ? 2'd0 : 2'(j - 1);
          lo = o ? (s[1:0] ^ st) : (s[1:0] + st);
          `CHK("burst address", ({a[18:2], lo}), memAddr_q)
          `CHK("burst read", 1'b1, memRead_q)
        end
      end
    end
    $display("test burst done");
    for (int i = 0; i < 7; i++)
    begin
      ln = (i < 4) ? ~(4'h1 << i) : ((i == 4) ? 4'hF : 4'h5);
      // the host model owns the write pins, so the pattern goes through a local copy
      wrN = (i < 5) ? 2'b10 : ((i == 5) ? 2'b01 : 2'b00);
      host_u.send(2'b10, 1'b1, wrN, ln, 3'b001, 19'h12340);
      nx(1'b1);
      `CHK("lane strobes", (i < 5) ? ~ln : 4'hF, memLaneWrite_q)
      `CHK("write no read", 1'b0, memRead_q)
    end
    $display("test writes done");
    for (int c = 0; c < 3; c++)
    begin
      host_u.send(2'b10, 1'b1, 2'b00, 4'h0, (c == 0) ? 3'b101 : ((c == 1) ? 3'b011 : 3'b000), 19'h00F00);
      nx(1'b0);
      `CHK("deselect write", 4'h0, memLaneWrite_q)
      nx(1'b0);
      `CHK("no burst after deselect", 1'b0, memRead_q)
    end
    host_u.send(2'b01, 1'b1, 2'b00, 4'h0, 3'b001, 19'h3C003);
    for (int k = 0; k < 3; k++)
    begin
      rd(19'h40001 + 19'(k));
      `CHK("strobe load address", ((k == 0) ? 19'h3C003 : 19'h40000 + 19'(k)), memAddr_q)
      `CHK("strobe load read", 1'b1, memRead_q)
      `CHK("strobe load no write", 4'h0, memLaneWrite_q)
    end
    // processor strobe with the first low enable high is ignored: the burst just suspends
    host_u.send(2'b01, 1'b1, 2'b11, 4'hF, 3'b101, 19'h7FFFF);
    nx(1'b1);
    `CHK("refused processor strobe", 19'h40003, memAddr_q)
    `CHK("refused strobe suspend read", 1'b1, memRead_q)
    $display("test strobes done");
    for (int t = 0; t < 4; t++)
    begin
      host_u.modeNext = ddMode[t];
      rd(19'h55554);
      if (t == 2)
        rd(19'h55558);
      else
        ds;
      `CHK("drive first", ddExp[t][1], dataDrive_q)
      `CHK("output register use", ddMode[t][2], outputRegUse_q)
      ds;
      `CHK("drive second", ddExp[t][0], dataDrive_q)
    end
    $display("test drive done");
    host_u.modeNext = 4'h5;
    rd(19'h00007);
    nx(1'b1);
    `CHK("sleep flag", 1'b1, sleepActive_q)
    `CHK("sleep ignores read", 1'b0, memRead_q)
    host_u.modeNext = 4'h4;
    nx(1'b0);
    nx(1'b0);
    `CHK("wake deselected", 1'b0, memRead_q)
    `CHK("wake flag", 1'b0, sleepActive_q)
    $display("test sleep done");
    print_verdict;
  end
endmodule
